// ==== hdl/tmr2_pkg.sv ====
// constants and field layout of the timer two capture/reload counter
// What this block does
// R1: sixteen-bit up/down counter, internal timer or external event counter by select bit.
// R2: select set counts count-input falling edges; cleared counts the internal clock.
// R3: counts only while run control is one; while zero holds value except on a trigger reload.
// R4: overflow or underflow sets overflow flag unless a baud select is set; stays set until software clears it.
// R5: capture mode without external enable is a plain timer setting only overflow flag.
// R6: capture mode with external enable: trigger fall copies counter into capture registers.
// R7: external flag raises the same timer interrupt as the overflow flag.
// R8: auto-reload mode loads counter from the reload register pair on overflow.
// R9: software writes reload registers before relying on auto-reload.
// R10: auto-reload with external enable: trigger fall reloads counter, sets external flag.
// R11: down-count disabled counts up; past FFFF sets overflow flag and reloads.
// R12: down-count enabled: trigger high counts up, trigger low counts down.
// R13: counting up with down-count enabled overflows at FFFF, sets flag, reloads.
// R14: counting down compares counter against reload value to detect underflow.
// R15: down count equal to reload loads FFFF and sets overflow flag.
// R16: up/down mode toggles external flag per wrap; no interrupt from it there.
// R17: baud select bits route this timer's overflow as serial rx/tx clock.
// R18: either baud select forces auto-reload on overflow, ignoring capture/reload select.
// R19: external enable set: capture/reload select one captures, zero reloads on trigger.
// R20: external flag set only by trigger-caused capture or reload with external enable, or by an up/down-mode wrap toggle.
// R21: count and trigger inputs synchronised; one falling edge acted on per sample.
// R22: reset clears control, counter, reload and capture: timer stopped, auto-reload mode.
package tmr2_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam int          ADDR_W      = 12;
  localparam logic [11:0] OFF_CTL     = 12'h418;
  localparam logic [11:0] OFF_MODE    = 12'h41C;
  localparam logic [11:0] OFF_COUNT   = 12'h420;
  localparam logic [11:0] OFF_RELOAD  = 12'h424;
  localparam logic [11:0] OFF_CAPTURE = 12'h428;

  // ==========================================================
  // control register fields
  localparam int BIT_OVF   = 7;
  localparam int BIT_EXT   = 6;
  localparam int BIT_RXSEL = 5;
  localparam int BIT_TXSEL = 4;
  localparam int BIT_EXEN  = 3;
  localparam int BIT_RUN   = 2;
  localparam int BIT_CT    = 1;
  localparam int BIT_CPRL  = 0;

  // mode register fields
  localparam int BIT_DOWN_COUNT_ENABLE  = 0;

  // ==========================================================
  // reset values and counter limits
  localparam logic [7:0]  CTL_RST  = 8'h00;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;

  // ==========================================================
  // internal clock prescaler
  localparam int          PRE_W    = 2;
  localparam logic [1:0]  PRE_LAST = 2'h3;

endpackage : tmr2_pkg

// ==== hdl/tmr2_edge_sync.sv ====
// two-flop synchroniser with falling-edge detector for a pin input
`timescale 1ns/1ps
module tmr2_edge_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin,
  output logic      level,
  output logic      fall
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } tmr2_sync_s;

  tmr2_sync_s q;
  tmr2_sync_s d;

  // meta is read only by the sync stage
  always_comb begin
    d      = q;
    d.meta = pin;
    d.sync = q.meta;
    d.prev = q.sync;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level = q.sync;
  assign fall  = q.prev & ~q.sync; // see R21

endmodule : tmr2_edge_sync

// ==== hdl/tmr2_prescale.sv ====
// divider giving one-cycle enable pulses for the internal count clock
`timescale 1ns/1ps
module tmr2_prescale (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tick
);

  typedef struct packed {
    logic [tmr2_pkg::PRE_W-1:0] cnt;
    logic                       tick;
  } tmr2_pre_s;

  tmr2_pre_s q;
  tmr2_pre_s d;

  always_comb begin
    d      = q;
    d.tick = (q.cnt == tmr2_pkg::PRE_LAST);
    d.cnt  = d.tick ? '0 : q.cnt + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;

endmodule : tmr2_prescale

// ==== hdl/tmr2_timer.sv ====
// timer two: counter, capture/reload, baud routing and apb registers
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module tmr2_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        count_input,
  input  wire logic        trigger_direction_input,
  input  wire logic        irq_enable,
  input  wire logic        other_timer_overflow,
  output logic             timer_irq,
  output logic             rx_baud_tick,
  output logic             tx_baud_tick
);

  // ==========================================================
  // state

  typedef struct packed {
    logic [7:0]  ctl;
    logic        down_count_enable;
    logic [15:0] cnt;
    logic [15:0] rld;
    logic [15:0] cap;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic        irq;
    logic        rxb;
    logic        txb;
  } tmr2_state_s;

  tmr2_state_s q;
  tmr2_state_s n;

  logic        pre_tick;
  logic        cnt_level;
  logic        cnt_fall;
  logic        trig_level;
  logic        trig_fall;

  logic        baud;
  logic        capmode;
  logic        updown;
  logic        up;
  logic        tick;
  logic        at_top;
  logic        at_floor;
  logic        ovf_ev;
  logic        trig_ev;

  logic        setup;
  logic        wr;
  logic        wr_ctl;
  logic        wr_mode;
  logic        wr_cnt;
  logic        wr_rld;
  logic        mapped;
  logic [31:0] rd_mux;

  // ==========================================================
  // helpers

  function automatic logic hit(
    input logic [11:0] addr,
    input logic [11:0] off
  );
    hit = (addr == off);
  endfunction : hit

  // ==========================================================
  // input conditioning

  tmr2_prescale u_pre (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (pre_tick)
  );

  tmr2_edge_sync u_cnt_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (count_input),
    .level   (cnt_level),
    .fall    (cnt_fall)
  );

  tmr2_edge_sync u_trig_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (trigger_direction_input),
    .level   (trig_level),
    .fall    (trig_fall)
  );

  // ==========================================================
  // mode decode

  // baud routing overrides capture and direction control
  assign baud    = q.ctl[tmr2_pkg::BIT_RXSEL]
                 | q.ctl[tmr2_pkg::BIT_TXSEL];
  assign capmode = q.ctl[tmr2_pkg::BIT_CPRL] & ~baud;    // see R18
  assign updown  = q.down_count_enable & ~capmode & ~baud;
  assign up      = ~updown | trig_level;                 // see R12

  // event counter needs a falling edge; timer uses prescaler
  assign tick = q.ctl[tmr2_pkg::BIT_RUN]                 // see R3
              & (q.ctl[tmr2_pkg::BIT_CT]
                 ? cnt_fall : pre_tick);                 // see R2

  assign at_top   = (q.cnt == tmr2_pkg::CNT_MAX);
  assign at_floor = (q.cnt == q.rld);                    // see R14
  assign ovf_ev   = tick & (up ? at_top : at_floor);

  // trigger acts even while stopped, as a capture strobe would
  assign trig_ev = trig_fall                             // see R19
                 & q.ctl[tmr2_pkg::BIT_EXEN]
                 & ~updown & ~baud;

  // ==========================================================
  // apb decode

  assign setup   = psel & ~penable;
  assign wr      = psel & penable & q.ready & pwrite & ~q.err;
  assign wr_ctl  = wr & hit(paddr, tmr2_pkg::OFF_CTL);
  assign wr_mode = wr & hit(paddr, tmr2_pkg::OFF_MODE);
  assign wr_cnt  = wr & hit(paddr, tmr2_pkg::OFF_COUNT);
  assign wr_rld  = wr & hit(paddr, tmr2_pkg::OFF_RELOAD); // see R9

  assign mapped = hit(paddr, tmr2_pkg::OFF_CTL)
                | hit(paddr, tmr2_pkg::OFF_MODE)
                | hit(paddr, tmr2_pkg::OFF_COUNT)
                | hit(paddr, tmr2_pkg::OFF_RELOAD)
                | hit(paddr, tmr2_pkg::OFF_CAPTURE);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      tmr2_pkg::OFF_CTL: begin
        rd_mux = 32'(q.ctl);
      end
      tmr2_pkg::OFF_MODE: begin
        rd_mux[tmr2_pkg::BIT_DOWN_COUNT_ENABLE] = q.down_count_enable;
      end
      tmr2_pkg::OFF_COUNT: begin
        rd_mux = 32'(q.cnt);
      end
      tmr2_pkg::OFF_RELOAD: begin
        rd_mux = 32'(q.rld);
      end
      tmr2_pkg::OFF_CAPTURE: begin
        rd_mux = 32'(q.cap);
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // ==========================================================
  // next state

  always_comb begin
    n = q;

    // bus answer: one wait-free access after each setup
    n.ready = setup;
    n.err   = setup & ~mapped;
    if (setup) begin
      n.rdata = pwrite ? 32'h0000_0000 : rd_mux;
    end

    // count step
    if (tick) begin
      if (up) begin
        if (at_top) begin
          // capture mode rolls to zero; others reload
          n.cnt = capmode ? tmr2_pkg::CNT_RST   // see R5
                          : q.rld;              // see R8 see R11 see R13
        end else begin
          n.cnt = q.cnt + 16'h0001;             // see R1
        end
      end else begin
        if (at_floor) begin
          n.cnt = tmr2_pkg::CNT_MAX;            // see R15
        end else begin
          n.cnt = q.cnt - 16'h0001;
        end
      end
    end

    // trigger falling edge: capture or reload
    if (trig_ev) begin
      if (capmode) begin
        n.cap = q.cnt;                          // see R6
      end else begin
        n.cnt = q.rld;                          // see R10
      end
    end

    // software writes
    if (wr_cnt) begin
      n.cnt = pwdata[15:0];
    end
    if (wr_rld) begin
      n.rld = pwdata[15:0];
    end
    if (wr_mode) begin
      n.down_count_enable = pwdata[tmr2_pkg::BIT_DOWN_COUNT_ENABLE];
    end
    if (wr_ctl) begin
      n.ctl = pwdata[7:0];
    end

    // hardware flag updates win over a clearing write
    if (ovf_ev && !baud) begin
      n.ctl[tmr2_pkg::BIT_OVF] = 1'b1;          // see R4
    end
    if (trig_ev) begin
      n.ctl[tmr2_pkg::BIT_EXT] = 1'b1;          // see R20
    end
    if (ovf_ev && updown) begin
      // seventeenth bit of the count
      n.ctl[tmr2_pkg::BIT_EXT] = ~n.ctl[tmr2_pkg::BIT_EXT]; // see R16
    end

    // timer interrupt; external flag silent in up/down mode
    n.irq = irq_enable
          & (q.ctl[tmr2_pkg::BIT_OVF]
             | (q.ctl[tmr2_pkg::BIT_EXT] & ~updown)); // see R7 see R16

    // baud clock sources
    n.rxb = q.ctl[tmr2_pkg::BIT_RXSEL] ? ovf_ev       // see R17
                                        : other_timer_overflow;
    n.txb = q.ctl[tmr2_pkg::BIT_TXSEL] ? ovf_ev
                                        : other_timer_overflow;
  end

  // ==========================================================
  // state register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;                                  // see R22
    end else begin
      q <= n;
    end
  end

  assign prdata       = q.rdata;
  assign pready       = q.ready;
  assign pslverr      = q.err;
  assign timer_irq    = q.irq;
  assign rx_baud_tick = q.rxb;
  assign tx_baud_tick = q.txb;

  // ==========================================================
  // assertions

  default clocking cb @(posedge pclk);
  endclocking

  default disable iff (!presetn);

  a_hold_stopped: assert property ( // see R3
    !q.ctl[tmr2_pkg::BIT_RUN] && !trig_ev && !wr_cnt |=> $stable(q.cnt))
    else $error("counter moved while stopped");

  a_count_up: assert property ( // see R1
    tick && up && !at_top && !trig_ev && !wr_cnt
    |=> q.cnt == $past(q.cnt) + 16'h0001)
    else $error("up count step wrong");

  a_ovf_flag: assert property ( // see R4
    ovf_ev && !baud |=> q.ctl[tmr2_pkg::BIT_OVF] ##1 (q.irq || !irq_enable))
    else $error("overflow flag or interrupt missing");

  a_wrap_reload: assert property ( // see R11
    tick && up && at_top && !capmode && !trig_ev && !wr_cnt
    |=> q.cnt == $past(q.rld))
    else $error("overflow reload wrong");

  a_capture_copy: assert property ( // see R6
    trig_ev && capmode |=> q.cap == $past(q.cnt) && q.ctl[tmr2_pkg::BIT_EXT])
    else $error("capture not taken");

  a_trig_reload: assert property ( // see R10
    trig_ev && !capmode && !wr_cnt |=> q.cnt == $past(q.rld))
    else $error("trigger reload missing");

  a_down_under: assert property ( // see R15
    tick && !up && at_floor && !trig_ev && !wr_cnt
    |=> q.cnt == tmr2_pkg::CNT_MAX)
    else $error("underflow load wrong");

  a_ext_toggle: assert property ( // see R16
    ovf_ev && updown && !wr_ctl
    |=> q.ctl[tmr2_pkg::BIT_EXT] != $past(q.ctl[tmr2_pkg::BIT_EXT]))
    else $error("external flag did not toggle");

  a_ext_cause: assert property ( // see R20
    !trig_ev && !(ovf_ev && updown) && !wr_ctl
    |=> !$rose(q.ctl[tmr2_pkg::BIT_EXT]))
    else $error("external flag set without cause");

  a_irq_ext: assert property ( // see R7
    irq_enable && q.ctl[tmr2_pkg::BIT_EXT] && !updown |=> timer_irq)
    else $error("external flag gave no interrupt");

  a_baud_route: assert property ( // see R17
    ovf_ev && q.ctl[tmr2_pkg::BIT_RXSEL] |=> rx_baud_tick)
    else $error("baud tick not routed");

  a_tx_route: assert property ( // see R17
    ovf_ev && q.ctl[tmr2_pkg::BIT_TXSEL] |=> tx_baud_tick)
    else $error("tx baud tick not routed");

  a_baud_no_flag: assert property ( // see R18
    ovf_ev && baud && !wr_ctl |=> !$rose(q.ctl[tmr2_pkg::BIT_OVF]))
    else $error("overflow flag set in baud mode");

  a_capture_wrap: assert property ( // see R5
    tick && up && at_top && capmode && !wr_cnt |=> q.cnt == tmr2_pkg::CNT_RST)
    else $error("capture mode wrap wrong");

  a_down_step: assert property ( // see R12
    tick && !up && !at_floor && !trig_ev && !wr_cnt
    |=> q.cnt == $past(q.cnt) - 16'h0001)
    else $error("down count step wrong");

  a_apb_ready: assert property (
    setup |=> pready)
    else $error("no ready after setup");

  a_apb_error: assert property (
    setup && !mapped |=> pready && pslverr)
    else $error("unmapped access gave no error");

  c_overflow:  cover property (ovf_ev && !updown);
  c_capture:   cover property (trig_ev && capmode);
  c_underflow: cover property (tick && !up && at_floor);
  c_baud:      cover property (ovf_ev && baud);

endmodule : tmr2_timer

// ==== tb/tmr2_pin_model.sv ====
// pin-side partner: drives the external count and trigger/direction pins
`timescale 1ns/1ps
module tmr2_pin_model (
  input  wire logic pclk,
  output logic      count_input,
  output logic      trigger_direction_input
);
  initial begin
    count_input = 1'b1;
    trigger_direction_input = 1'b1;
  end

  // ==========================================================
  // every level held three cycles or more so the synchroniser never misses an edge
  task automatic pulse_count(input int n);
    repeat (n) begin
      @(posedge pclk) count_input <= 1'b0;
      repeat (3) @(posedge pclk);
      count_input <= 1'b1;
      repeat (3) @(posedge pclk);
    end
  endtask : pulse_count

  task automatic trigger_fall();
    @(posedge pclk) trigger_direction_input <= 1'b0;
    repeat (4) @(posedge pclk);
    trigger_direction_input <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask : trigger_fall

  task automatic set_dir(input logic v);
    @(posedge pclk) trigger_direction_input <= v;
    repeat (4) @(posedge pclk);
  endtask : set_dir
endmodule : tmr2_pin_model

// ==== tb/tb_timer2_capture_reload_counter.sv ====
// self-checking bench for the timer two capture/reload counter
`timescale 1ns/1ps
module tb_timer2_capture_reload_counter;
  localparam logic [11:0] A_CTL = tmr2_pkg::OFF_CTL;
  localparam logic [11:0] A_CNT = tmr2_pkg::OFF_COUNT;
  localparam logic [11:0] A_RL  = tmr2_pkg::OFF_RELOAD;
  localparam logic [11:0] A_CAP = tmr2_pkg::OFF_CAPTURE;
  localparam logic [11:0] A_MOD = tmr2_pkg::OFF_MODE;
  localparam logic [11:0] REGS [5] = '{A_CTL, A_MOD, A_CNT, A_RL, A_CAP};
  localparam logic [31:0] OVF  = 32'h1 << tmr2_pkg::BIT_OVF;
  localparam logic [31:0] EXT  = 32'h1 << tmr2_pkg::BIT_EXT;
  localparam logic [31:0] RXS  = 32'h1 << tmr2_pkg::BIT_RXSEL;
  localparam logic [31:0] TXS  = 32'h1 << tmr2_pkg::BIT_TXSEL;
  localparam logic [31:0] EXEN = 32'h1 << tmr2_pkg::BIT_EXEN;
  localparam logic [31:0] RUN  = 32'h1 << tmr2_pkg::BIT_RUN;
  localparam logic [31:0] CT   = 32'h1 << tmr2_pkg::BIT_CT;
  localparam logic [31:0] CPRL = 32'h1 << tmr2_pkg::BIT_CPRL;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        count_input, trigger_direction_input, irq_enable, other_timer_overflow;
  logic        timer_irq, rx_baud_tick, tx_baud_tick;
  logic [15:0] rl, ex;
  int          num_errors = 0, checked = 0, cycles = 0, rx_n = 0, tx_n = 0, n, k;

  tmr2_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_input(count_input), .trigger_direction_input(trigger_direction_input),
    .irq_enable(irq_enable), .other_timer_overflow(other_timer_overflow), .timer_irq(timer_irq),
    .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick));
  tmr2_pin_model pins (.pclk(pclk), .count_input(count_input),
    .trigger_direction_input(trigger_direction_input));

  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (rx_baud_tick === 1'b1) rx_n <= rx_n + 1;
    if (tx_baud_tick === 1'b1) tx_n <= tx_n + 1;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end

  // ==========================================================
  // expected next count of the up/down auto-reload counter
  function automatic logic [15:0] step(input logic [15:0] v, r, input logic up);
    if (up) return (v == 16'hFFFF) ? r : v + 16'h1;
    return (v == r) ? 16'hFFFF : v - 16'h1;
  endfunction : step

  task automatic chk(input string what, input logic [31:0] exp, got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one apb transfer; waits on pready, no fixed latency assumed
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rchk

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, irq_enable, other_timer_overflow} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    void'($urandom(25));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (REGS[i]) rchk("reset value", REGS[i], 32'h0);
    apb(1'b0, 12'h400, 32'h0);
    chk("unmapped error", 32'h1, 32'(err));
    $display("test reset done");
    // internal clock, up count through FFFF into the reload value
    rl = 16'hFF80 + 16'($urandom_range(63));
    irq_enable <= 1'b1;
    wr(A_RL, 32'(rl));
    wr(A_CNT, 32'h0000FFFE);
    wr(A_CTL, RUN);
    repeat (40) @(posedge pclk);
    chk("overflow irq", 32'h1, 32'(timer_irq));
    rchk("overflow flag", A_CTL, RUN | OVF);
    wr(A_CTL, OVF);
    apb(1'b0, A_CNT, 32'h0);
    chk("count reloaded", 32'h1, 32'(rd >= rl && rd <= rl + 16));
    rchk("flag stays", A_CTL, OVF);
    wr(A_CTL, 32'h0);
    // interrupt output is registered from the flag: allow it to settle
    repeat (2) @(posedge pclk);
    chk("irq cleared", 32'h0, 32'(timer_irq));
    $display("test up reload done");
    wr(A_CNT, 32'h0);
    wr(A_CTL, RUN | CT);
    n = 3 + $urandom_range(5);
    pins.pulse_count(n);
    rchk("event count", A_CNT, 32'(n));
    wr(A_CTL, CT);
    pins.pulse_count(2);
    rchk("stopped count", A_CNT, 32'(n));
    $display("test event count done");
    wr(A_CNT, 32'h1234);
    wr(A_CTL, RUN | CT | CPRL);
    pins.trigger_fall();
    rchk("no capture", A_CAP, 32'h0);
    rchk("no ext flag", A_CTL, RUN | CT | CPRL);
    wr(A_CTL, RUN | CT | CPRL | EXEN);
    pins.trigger_fall();
    rchk("capture", A_CAP, 32'h1234);
    rchk("capture flag", A_CTL, RUN | CT | CPRL | EXEN | EXT);
    chk("ext irq", 32'h1, 32'(timer_irq));
    rl = 16'($urandom());
    wr(A_RL, 32'(rl));
    wr(A_CTL, RUN | CT | EXEN);
    pins.trigger_fall();
    rchk("trigger reload", A_CNT, 32'(rl));
    rchk("reload flag", A_CTL, RUN | CT | EXEN | EXT);
    $display("test capture reload done");
    wr(A_CTL, 32'h0);
    wr(A_MOD, 32'h1 << tmr2_pkg::BIT_DOWN_COUNT_ENABLE);
    pins.set_dir(1'b0);
    rl = 16'h0100 + 16'($urandom_range(255));
    ex = rl + 16'h1;
    wr(A_RL, 32'(rl));
    wr(A_CNT, 32'(ex));
    wr(A_CTL, RUN | CT);
    for (int i = 0; i < 3; i++) begin
      if (i == 2) pins.set_dir(1'b1);
      pins.pulse_count(1);
      ex = step(ex, rl, i == 2);
      rchk("up down count", A_CNT, 32'(ex));
      if (i == 1) rchk("underflow flags", A_CTL, RUN | CT | OVF | EXT);
    end
    rchk("wrap flags", A_CTL, RUN | CT | OVF);
    $display("test up down done");
    wr(A_CTL, 32'h0);
    wr(A_MOD, 32'h0);
    wr(A_RL, 32'h0000FFFC);
    wr(A_CNT, 32'h0000FFFC);
    wr(A_CTL, RUN | RXS | CPRL);
    n = rx_n;
    k = tx_n;
    repeat (3) begin
      @(posedge pclk) other_timer_overflow <= 1'b1;
      @(posedge pclk) other_timer_overflow <= 1'b0;
    end
    repeat (60) @(posedge pclk);
    chk("rx baud ticks", 32'h1, 32'(rx_n - n > 2));
    chk("tx other ticks", 32'h3, 32'(tx_n - k));
    rchk("baud flags", A_CTL, RUN | RXS | CPRL);
    wr(A_CTL, 32'h0);
    apb(1'b0, A_CNT, 32'h0);
    chk("baud reloads", 32'h1, 32'(rd >= 32'hFFFC && rd <= 32'hFFFF));
    wr(A_CTL, RUN | TXS);
    k = tx_n;
    repeat (60) @(posedge pclk);
    chk("tx baud ticks", 32'h1, 32'(tx_n - k > 2));
    rchk("tx baud flags", A_CTL, RUN | TXS);
    wr(A_CTL, 32'h0);
    $display("test baud done");
    complete_run();
  end
endmodule : tb_timer2_capture_reload_counter
